// [rtl/shi_ctrl.sv]
// Host interface controller: interface selection, I2C slave, register file and output rate timing.
`timescale 1ns/10ps
module shi_ctrl
	import shi_pkg::*;
#(
	parameter int BASE_CYCLES = BASE_PERIOD_CYCLES
)
(
	// System
	input wire logic CLK_SYS,
	input wire logic RST,
	// Serial pins
	input wire logic SERIAL_CLK,
	input wire logic CHIP_SELECT_N,
	input wire logic SERIAL_DATA_IN,
	output logic SERIAL_DATA_OUT,
	output logic SERIAL_DATA_OE_N,
	input wire logic ADDRESS_SELECT_PIN,
	output logic ADDRESS_SELECT_OUT,
	output logic ADDRESS_SELECT_OE_N,
	// Measurement control
	output logic SAMPLE_TICK,
	output logic [6:0] IIR_COEF,
	output logic FIFO_FLUSH,
	output logic SOFT_RESET
);

	localparam int BASE_W = $clog2(BASE_CYCLES + 1);

	logic [3:0] pin_s;
	logic scl_s, sda_s, csn_s, adsel_s;
	logic scl_d, sda_d;
	logic scl_rise, scl_fall, start, stop;
	logic i2c_locked, i2c_en;
	logic [6:0] i2c_addr;
	shi_i2c_st_t st, after_st;
	logic [3:0] bit_cnt;
	logic [7:0] shift, tx, reg_addr;
	logic sda_low, nack;
	logic i2c_wr_en;
	shi_wr_t i2c_wr;
	logic [7:0] rd_byte, rd_next;
	logic frame_clr;
	logic spi_sdo, spi_drive;
	shi_wr_t spi_wr;
	logic spi_wr_tgl, spi_rd_tgl;
	logic [7:0] spi_rd_addr;
	logic [1:0] tgl_s;
	logic wr_seen, rd_seen, rd_ack_tgl, spi_wr_ev;
	logic [7:0] rd_resp;
	logic wr_en;
	shi_wr_t wr;
	logic cmd_wr, soft_rst_cmd;
	logic [4:0] odr;
	logic [2:0] iir;
	logic three_wire;
	logic [BASE_W-1:0] base_cnt;
	logic [PRESCALE_W-1:0] pre_cnt, pre_limit;

	// ****************************************
	// Register read decode
	// ****************************************
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			REG_ODR: r[ODR_POS +: ODR_W] = odr;
			REG_FILTER_SETUP: r[IIR_POS +: IIR_W] = iir;
			REG_IF_CONF: r[THREE_WIRE_POS] = three_wire;
			REG_COMMAND_TRIGGER: r = 8'h00;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// ****************************************
	// Pin synchronisers and interface selection
	// ****************************************
	// Chip select resets high: a host that wants I2C must hold it so through reset.
	shi_sync #(.WIDTH(4), .RESET_VALUE(4'hE)) u_pin_sync (
		.clk(CLK_SYS),
		.rst(RST),
		.async_in({SERIAL_CLK, SERIAL_DATA_IN, CHIP_SELECT_N, ADDRESS_SELECT_PIN}),
		.sync_out(pin_s)
	);
	assign {scl_s, sda_s, csn_s, adsel_s} = pin_s;

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			i2c_locked <= 1'h0;
		else if (!csn_s)
			i2c_locked <= 1'h1;
	end

	assign i2c_en = csn_s && !i2c_locked;
	assign i2c_addr = {I2C_ADDR_HIGH, adsel_s};

	// ****************************************
	// I2C bus conditions
	// ****************************************
	// Oversampling at the system clock covers all three bus speeds.
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			scl_d <= 1'h1;
			sda_d <= 1'h1;
		end
		else
		begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start = scl_s && scl_d && sda_d && !sda_s;
	assign stop = scl_s && scl_d && !sda_d && sda_s;
	// A process rather than an assignment, so that a register change alone refreshes the read data.
	always_comb
	begin
		rd_byte = reg_read(reg_addr);
		rd_next = reg_read(reg_addr + 8'h01);
	end

	// ****************************************
	// I2C slave
	// ****************************************
	always_ff @(posedge CLK_SYS)
	begin
		if (RST || !i2c_en)
		begin
			st <= I2C_IDLE;
			after_st <= I2C_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			tx <= 8'h00;
			reg_addr <= 8'h00;
			sda_low <= 1'h0;
			nack <= 1'h0;
			i2c_wr_en <= 1'h0;
			i2c_wr <= '0;
		end
		else
		begin
			i2c_wr_en <= 1'h0;
			if (start)
			begin
				st <= I2C_ADDR;
				bit_cnt <= 4'h0;
				sda_low <= 1'h0;
			end
			else if (stop)
			begin
				st <= I2C_IDLE;
				sda_low <= 1'h0;
			end
			else
			begin
				case (st)
					I2C_ADDR, I2C_REG, I2C_WDATA:
					begin
						if (scl_rise)
						begin
							shift <= {shift[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end
						else if (scl_fall && bit_cnt == 4'h8)
						begin
							bit_cnt <= 4'h0;
							st <= I2C_ACK;
							sda_low <= 1'h1;
							if (st == I2C_ADDR)
							begin
								if (shift[7:1] != i2c_addr)
								begin
									st <= I2C_IDLE;
									sda_low <= 1'h0;
								end
								after_st <= shift[0] ? I2C_RDATA : I2C_REG;
							end
							else if (st == I2C_REG)
							begin
								reg_addr <= shift;
								after_st <= I2C_WDATA;
							end
							else
							begin
								i2c_wr_en <= 1'h1;
								i2c_wr <= '{addr: reg_addr, data: shift};
								after_st <= I2C_REG;
							end
						end
					end
					I2C_ACK:
					begin
						if (scl_fall)
						begin
							st <= after_st;
							bit_cnt <= (after_st == I2C_RDATA) ? 4'h1 : 4'h0;
							tx <= {rd_byte[6:0], 1'h0};
							sda_low <= (after_st == I2C_RDATA) && !rd_byte[7];
						end
					end
					I2C_RDATA:
					begin
						if (scl_fall)
						begin
							if (bit_cnt == 4'h8)
							begin
								sda_low <= 1'h0;
								st <= I2C_MACK;
							end
							else
							begin
								sda_low <= !tx[7];
								tx <= {tx[6:0], 1'h0};
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
					I2C_MACK:
					begin
						if (scl_rise)
							nack <= sda_s;
						else if (scl_fall)
						begin
							if (nack)
								st <= I2C_IDLE;
							else
							begin
								reg_addr <= reg_addr + 8'h01;
								tx <= {rd_next[6:0], 1'h0};
								sda_low <= !rd_next[7];
								bit_cnt <= 4'h1;
								st <= I2C_RDATA;
							end
						end
					end
					default:
						st <= I2C_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// SPI link and its crossing
	// ****************************************
	assign frame_clr = CHIP_SELECT_N | RST;

	shi_spi_link u_spi (
		.sck(SERIAL_CLK),
		.frame_clr(frame_clr),
		.link_rst(RST),
		.sdi(SERIAL_DATA_IN),
		.address_select_pin(spi_sdo),
		.drive(spi_drive),
		.wr(spi_wr),
		.wr_tgl(spi_wr_tgl),
		.rd_addr(spi_rd_addr),
		.rd_req_tgl(spi_rd_tgl),
		.rd_resp(rd_resp),
		.rd_ack_tgl(rd_ack_tgl)
	);

	shi_sync #(.WIDTH(2), .RESET_VALUE(2'h0)) u_tgl_sync (
		.clk(CLK_SYS),
		.rst(RST),
		.async_in({spi_wr_tgl, spi_rd_tgl}),
		.sync_out(tgl_s)
	);

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			wr_seen <= 1'h0;
			rd_seen <= 1'h0;
			rd_ack_tgl <= 1'h0;
			rd_resp <= 8'h00;
		end
		else
		begin
			wr_seen <= tgl_s[1];
			rd_seen <= tgl_s[0];
			if (tgl_s[0] != rd_seen)
			begin
				rd_resp <= reg_read(spi_rd_addr);
				rd_ack_tgl <= ~rd_ack_tgl;
			end
		end
	end

	assign spi_wr_ev = tgl_s[1] != wr_seen;

	// ****************************************
	// Register file and commands
	// ****************************************
	assign wr_en = i2c_wr_en || spi_wr_ev;
	assign wr = i2c_wr_en ? i2c_wr : spi_wr;
	assign cmd_wr = wr_en && wr.addr == REG_COMMAND_TRIGGER;
	assign soft_rst_cmd = cmd_wr && wr.data == CMD_SOFT_RESET;

	always_ff @(posedge CLK_SYS)
	begin
		if (RST || soft_rst_cmd)
		begin
			odr <= ODR_RESET;
			iir <= IIR_RESET;
			three_wire <= THREE_WIRE_RESET;
		end
		else if (wr_en)
		begin
			case (wr.addr)
				REG_ODR: odr <= (wr.data[ODR_POS +: ODR_W] > ODR_MAX) ? ODR_MAX : wr.data[ODR_POS +: ODR_W];
				REG_FILTER_SETUP: iir <= wr.data[IIR_POS +: IIR_W];
				REG_IF_CONF: three_wire <= wr.data[THREE_WIRE_POS];
				default: ;
			endcase
		end
	end

	// Unlisted codes and the no-operation code fall through with no pulse.
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			FIFO_FLUSH <= 1'h0;
			SOFT_RESET <= 1'h0;
		end
		else
		begin
			FIFO_FLUSH <= cmd_wr && wr.data == CMD_FIFO_FLUSH;
			SOFT_RESET <= soft_rst_cmd;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			IIR_COEF <= 7'h00;
		else
			IIR_COEF <= 7'((8'h01 << iir) - 8'h01);
	end

	// ****************************************
	// Output rate timing
	// ****************************************
	assign pre_limit = PRESCALE_W'((PRESCALE_W'(1) << odr) - PRESCALE_W'(1));

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			base_cnt <= '0;
			pre_cnt <= '0;
			SAMPLE_TICK <= 1'h0;
		end
		else
		begin
			SAMPLE_TICK <= 1'h0;
			if (base_cnt == BASE_W'(BASE_CYCLES - 1))
			begin
				base_cnt <= '0;
				if (pre_cnt >= pre_limit)
				begin
					pre_cnt <= '0;
					SAMPLE_TICK <= 1'h1;
				end
				else
					pre_cnt <= pre_cnt + PRESCALE_W'(1);
			end
			else
				base_cnt <= base_cnt + BASE_W'(1);
		end
	end

	// ****************************************
	// Pins
	// ****************************************
	assign SERIAL_DATA_OUT = spi_drive ? spi_sdo : 1'h0;
	assign SERIAL_DATA_OE_N = !((spi_drive && three_wire) || sda_low);
	assign ADDRESS_SELECT_OUT = spi_sdo;
	assign ADDRESS_SELECT_OE_N = !(spi_drive && !three_wire);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	logic [47:0] since_tick;
	logic tick_valid;

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			since_tick <= 48'h0;
			tick_valid <= 1'h0;
		end
		else if (SAMPLE_TICK)
		begin
			since_tick <= 48'h0;
			tick_valid <= 1'h1;
		end
		else
		begin
			since_tick <= since_tick + 48'h1;
			if (wr_en && (wr.addr == REG_ODR || soft_rst_cmd))
				tick_valid <= 1'h0;
		end
	end

	sequence s_cmd_write(logic [7:0] code);
		cmd_wr && wr.data == code;
	endsequence

	sequence s_data_done;
		i2c_en && st == I2C_WDATA && scl_fall && bit_cnt == 4'h8 && !start && !stop;
	endsequence

	a_flush_pulse: assert property (s_cmd_write(CMD_FIFO_FLUSH) |=> FIFO_FLUSH && !SOFT_RESET)
		else $error("Flush pulse missing.");
	a_soft_reset: assert property (s_cmd_write(CMD_SOFT_RESET)
		|=> SOFT_RESET && odr == ODR_RESET && iir == IIR_RESET) else $error("Soft reset failed.");
	a_cmd_zero: assert property (s_cmd_write(CMD_NOP) |=> !FIFO_FLUSH && !SOFT_RESET
		&& reg_read(REG_COMMAND_TRIGGER) == 8'h00) else $error("Command register misbehaves.");
	a_odr_saturate: assert property (wr_en && wr.addr == REG_ODR && wr.data[4:0] > ODR_MAX
		|=> odr == ODR_MAX) else $error("Rate not saturated.");
	a_lock_set: assert property ($fell(csn_s) |=> i2c_locked [*3]) else $error("Lockout not held.");
	a_i2c_silent: assert property (i2c_locked |=> st == I2C_IDLE && !sda_low)
		else $error("I2C active while locked.");
	a_addr_reject: assert property (i2c_en && st == I2C_ADDR && scl_fall && bit_cnt == 4'h8
		&& !start && !stop && shift[7:1] != i2c_addr |=> st == I2C_IDLE && !sda_low)
		else $error("Foreign address taken.");
	a_auto_inc: assert property (i2c_en && st == I2C_MACK && scl_fall && !nack && !start && !stop
		|=> reg_addr == $past(reg_addr) + 8'h01) else $error("Read address not advanced.");
	a_write_pair: assert property (s_data_done |=> i2c_wr_en && i2c_wr.data == $past(shift)
		&& i2c_wr.addr == $past(reg_addr) ##1 !i2c_wr_en) else $error("Write pair lost.");
	a_iir_map: assert property ($stable(iir) |=> IIR_COEF == (7'h7F >> (3'h7 - $past(iir))))
		else $error("Filter coefficient wrong.");
	a_tick_period: assert property (SAMPLE_TICK && tick_valid
		|-> since_tick == (48'(BASE_CYCLES) << odr) - 48'h1) else $error("Sample period wrong.");

endmodule

// [rtl/shi_pkg.sv]
// Package with the register map, command codes, timing constants and types of the sensor host interface.
// Function
// - Sample period is 5 ms times two^code.
// - Three-bit field selects IIR coefficient or bypass.
// - Command register always reads zero; zero does nothing.
// - Command 0xB0 flushes FIFO, keeps its configuration.
// - Command 0xB6 restores all user settings to default.
// - Slave only; SPI modes 00 and 11, 3/4-wire.
// - Multi-byte write uses address and data pairs.
// - Multi-byte read auto-increments the register address.
// - Chip select high means I2C, low means SPI.
// - First low chip select locks out I2C.
// - I2C slave supports standard, fast and high-speed.
// - Address is six fixed bits plus live pin.
// - I2C uses clock pin and open-drain data pin.
// - Output rate codes above 17 saturate to 17.
package shi_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] REG_IF_CONF = 8'h1A;
	localparam logic [7:0] REG_ODR = 8'h1D;
	localparam logic [7:0] REG_FILTER_SETUP = 8'h1F;
	localparam logic [7:0] REG_COMMAND_TRIGGER = 8'h7E;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int ODR_POS = 0;
	localparam int ODR_W = 5;
	localparam logic [4:0] ODR_RESET = 5'h00;
	localparam logic [4:0] ODR_MAX = 5'h11;
	localparam int IIR_POS = 1;
	localparam int IIR_W = 3;
	localparam logic [2:0] IIR_RESET = 3'h0;
	localparam int THREE_WIRE_POS = 0;
	localparam logic THREE_WIRE_RESET = 1'h0;

	// ****************************************
	// Command codes and bus address
	// ****************************************
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_FIFO_FLUSH = 8'hB0;
	localparam logic [7:0] CMD_SOFT_RESET = 8'hB6;
	localparam logic [5:0] I2C_ADDR_HIGH = 6'h3B;

	// ****************************************
	// Timing
	// ****************************************
	localparam int SYS_CLK_PERIOD_NS = 20;
	localparam int BASE_PERIOD_MS = 5;
	localparam int BASE_PERIOD_CYCLES = BASE_PERIOD_MS * 1000000 / SYS_CLK_PERIOD_NS;
	localparam int PRESCALE_W = 18;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} shi_wr_t;

	typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_REG, I2C_WDATA, I2C_ACK, I2C_RDATA, I2C_MACK} shi_i2c_st_t;

	typedef enum logic [1:0] {SPI_CTRL, SPI_WDATA, SPI_DUMMY, SPI_RDATA} shi_spi_ph_t;

endpackage

// [rtl/shi_sync.sv]
// Two flip-flop synchroniser for a group of independent levels.
`timescale 1ns/10ps
module shi_sync
	import shi_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// [rtl/shi_spi_link.sv]
// SPI slave running on the serial clock, exchanging writes and reads with the system side by toggles.
`timescale 1ns/10ps
module shi_spi_link
	import shi_pkg::*;
(
	// Link clock and resets
	input wire logic sck,
	input wire logic frame_clr,
	input wire logic link_rst,
	// Serial data
	input wire logic sdi,
	output logic address_select_pin,
	output logic drive,
	// Write towards the system side
	output shi_wr_t wr,
	output logic wr_tgl,
	// Read towards the system side
	output logic [7:0] rd_addr,
	output logic rd_req_tgl,
	input wire logic [7:0] rd_resp,
	input wire logic rd_ack_tgl
);

	shi_spi_ph_t phase;
	logic [2:0] bit_cnt;
	logic [6:0] rx;
	logic [6:0] addr;
	logic [7:0] tx;
	logic [7:0] next_byte;
	logic byte_end;
	logic read_step;
	logic ack_meta;
	logic ack_s;

	assign next_byte = {rx, sdi};
	assign byte_end = bit_cnt == 3'h7;
	assign read_step = byte_end && ((phase == SPI_CTRL && next_byte[7]) || phase == SPI_DUMMY || phase == SPI_RDATA);
	assign rd_addr = {1'h0, addr};

	// ****************************************
	// Acknowledge crossing
	// ****************************************
	always_ff @(posedge sck or posedge link_rst)
	begin
		if (link_rst)
		begin
			ack_meta <= 1'h0;
			ack_s <= 1'h0;
		end
		else
		begin
			ack_meta <= rd_ack_tgl;
			ack_s <= ack_meta;
		end
	end

	// ****************************************
	// Frame state
	// ****************************************
	// Both supported modes sample on the rising edge, so one decoder serves them.
	always_ff @(posedge sck or posedge frame_clr)
	begin
		if (frame_clr)
		begin
			phase <= SPI_CTRL;
			bit_cnt <= 3'h0;
			rx <= 7'h00;
			addr <= 7'h00;
			tx <= 8'h00;
		end
		else
		begin
			rx <= next_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (phase == SPI_RDATA)
				tx <= {tx[6:0], 1'h0};
			if (byte_end)
			begin
				case (phase)
					SPI_CTRL:
					begin
						addr <= next_byte[6:0];
						phase <= next_byte[7] ? SPI_DUMMY : SPI_WDATA;
					end
					SPI_WDATA:
						phase <= SPI_CTRL;
					SPI_DUMMY, SPI_RDATA:
					begin
						// A late answer reads as zero rather than stalling the shifter.
						phase <= SPI_RDATA;
						tx <= (ack_s == rd_req_tgl) ? rd_resp : 8'h00;
						addr <= addr + 7'h01;
					end
					default:
						phase <= SPI_CTRL;
				endcase
			end
		end
	end

	// ****************************************
	// Requests to the system side
	// ****************************************
	// Toggles survive frame ends so the system side never sees a false event.
	always_ff @(posedge sck or posedge link_rst)
	begin
		if (link_rst)
		begin
			wr <= '0;
			wr_tgl <= 1'h0;
			rd_req_tgl <= 1'h0;
		end
		else
		begin
			if (byte_end && phase == SPI_WDATA && !frame_clr)
			begin
				wr <= '{addr: {1'h0, addr}, data: next_byte};
				wr_tgl <= ~wr_tgl;
			end
			if (read_step && !frame_clr)
				rd_req_tgl <= ~rd_req_tgl;
		end
	end

	// ****************************************
	// Output shifter
	// ****************************************
	always_ff @(negedge sck or posedge frame_clr)
	begin
		if (frame_clr)
		begin
			address_select_pin <= 1'h0;
			drive <= 1'h0;
		end
		else
		begin
			address_select_pin <= tx[7];
			drive <= phase == SPI_RDATA;
		end
	end

endmodule

// [testbench/shi_host.sv]
// Host master model that drives the serial pins for I2C and SPI mode 00 and 11 transfers.
`timescale 1ns/10ps
module shi_host
	import shi_pkg::*;
(
	// Pacing clock
	input wire logic clk,
	// Serial pins
	output logic sck,
	output logic csn,
	output logic sda_drv,
	input wire logic sda,
	input wire logic miso
);
	// I2C half period in system cycles; slow so the two-flop samplers see every level.
	localparam int HALF = 10;
	// Idle clock level around SPI frames: high for mode 11, low for mode 00.
	logic cpol = 1'b1;

	initial
	begin
		sck = 1'b1;
		csn = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	// ****************************************
	// I2C
	// ****************************************
	task automatic i2c_start();
		sda_drv = 1'b1;
		wait_clk(HALF);
		sck = 1'b1;
		wait_clk(HALF);
		sda_drv = 1'b0;
		wait_clk(HALF);
		sck = 1'b0;
	endtask

	task automatic i2c_stop();
		wait_clk(2);
		sda_drv = 1'b0;
		wait_clk(HALF);
		sck = 1'b1;
		wait_clk(HALF);
		sda_drv = 1'b1;
		wait_clk(HALF);
	endtask

	// Data only moves while the clock is low, a little after its fall.
	task automatic i2c_bit(input logic b, output logic r);
		wait_clk(2);
		sda_drv = b;
		wait_clk(HALF);
		sck = 1'b1;
		wait_clk(HALF);
		r = sda;
		sck = 1'b0;
	endtask

	task automatic i2c_byte(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			i2c_bit(tx[i], rx[i]);
		i2c_bit(last, ack);
	endtask

	// ****************************************
	// SPI
	// ****************************************
	// The clock pauses high after each byte so the read answer can cross domains.
	task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sck = 1'b0;
			sda_drv = tx[i];
			#6;
			sck = 1'b1;
			rx[i] = miso;
			if (i == 0)
				wait_clk(10);
			else
				#6;
		end
	endtask

	task automatic spi_frame(input logic [7:0] b0, input logic [7:0] b1, input int n, output logic [7:0] rx);
		sck = cpol;
		wait_clk(2);
		csn = 1'b0;
		wait_clk(2);
		spi_byte(b0, rx);
		spi_byte(b1, rx);
		if (n == 3)
			spi_byte(8'hFF, rx);
		sck = cpol;
		wait_clk(10);
		csn = 1'b1;
		sda_drv = 1'b1;
		wait_clk(4);
	endtask
endmodule

// [testbench/shi_ctrl_tb.sv]
// Self-checking testbench for the sensor host interface controller.
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module shi_ctrl_tb
	import shi_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic strap = 1'b0;
	wire host_sck, host_csn, host_sda, sda_w, asel_w;
	logic sample_tick, fifo_flush, soft_reset, sd_out, sd_oe_n, as_out, as_oe_n, ack;
	logic [6:0] iir_coef, e;
	logic [7:0] rx;
	logic [23:0] d;
	int n_mismatch = 0;
	int comparisons = 0;
	int n_flush = 0;
	int n_sreset = 0;
	int cyc = 0;
	int last_tick = 0;
	int tick_gap = 0;

	always #10 clk_sys = ~clk_sys;

	// Open-drain data line with pull-up; address pin carries the strap unless driven.
	assign sda_w = host_sda & (sd_oe_n | sd_out);
	assign asel_w = as_oe_n ? strap : as_out;

	shi_ctrl #(.BASE_CYCLES(10)) i_shi_ctrl (.CLK_SYS(clk_sys), .RST(rst), .SERIAL_CLK(host_sck),
		.CHIP_SELECT_N(host_csn), .SERIAL_DATA_IN(sda_w), .SERIAL_DATA_OUT(sd_out), .SERIAL_DATA_OE_N(sd_oe_n),
		.ADDRESS_SELECT_PIN(asel_w), .ADDRESS_SELECT_OUT(as_out), .ADDRESS_SELECT_OE_N(as_oe_n),
		.SAMPLE_TICK(sample_tick), .IIR_COEF(iir_coef), .FIFO_FLUSH(fifo_flush), .SOFT_RESET(soft_reset));

	shi_host i_shi_host (.clk(clk_sys), .sck(host_sck), .csn(host_csn), .sda_drv(host_sda), .sda(sda_w),
		.miso(asel_w & sda_w));

	always @(negedge clk_sys)
	begin
		cyc++;
		if (fifo_flush === 1'b1)
			n_flush++;
		if (soft_reset === 1'b1)
			n_sreset++;
		if (sample_tick === 1'b1)
		begin
			tick_gap = cyc - last_tick;
			last_tick = cyc;
		end
	end

	// ****************************************
	// Register access
	// ****************************************
	task automatic reg_wr(input logic [6:0] dev, input logic [31:0] b, input int npair, output logic a);
		logic x;
		i_shi_host.i2c_start();
		i_shi_host.i2c_byte({dev, 1'b0}, 1'b1, rx, a);
		for (int k = 0; k < 2 * npair; k++)
			i_shi_host.i2c_byte(b[31 - 8 * k -: 8], 1'b1, rx, x);
		i_shi_host.i2c_stop();
	endtask

	task automatic reg_rd(input logic [6:0] dev, input logic [7:0] ra, input int n, output logic [23:0] v);
		logic x;
		v = 24'h000000;
		i_shi_host.i2c_start();
		i_shi_host.i2c_byte({dev, 1'b0}, 1'b1, rx, x);
		i_shi_host.i2c_byte(ra, 1'b1, rx, x);
		i_shi_host.i2c_start();
		i_shi_host.i2c_byte({dev, 1'b1}, 1'b1, rx, x);
		for (int k = 0; k < n; k++)
		begin
			i_shi_host.i2c_byte(8'hFF, (k == n - 1), rx, x);
			v = {v[15:0], rx};
		end
		i_shi_host.i2c_stop();
	endtask

	task automatic close_out();
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		`CHK(iir_coef, 7'h00)
		i_shi_host.wait_clk(6);
		reg_wr(7'h76, {REG_ODR, 8'h02, REG_FILTER_SETUP, 8'h0A}, 2, ack);
		`CHK(ack, 1'b0)
		`CHK(iir_coef, 7'h1F)
		reg_rd(7'h76, REG_ODR, 3, d);
		`CHK(d, 24'h02000A)
		i_shi_host.wait_clk(100);
		`CHK(tick_gap, 40)
		reg_wr(7'h76, {REG_ODR, 8'h1F, 16'h0000}, 1, ack);
		reg_rd(7'h76, REG_ODR, 1, d);
		`CHK(d[7:0], 8'h11)
		for (int c = 0; c < 8; c++)
		begin
			reg_wr(7'h76, {REG_FILTER_SETUP, 4'h0, c[2:0], 1'b0, 16'h0000}, 1, ack);
			e = (7'h01 << c) - 7'h01;
			`CHK(iir_coef, e)
		end
		strap = 1'b1;
		reg_wr(7'h76, {REG_FILTER_SETUP, 8'h02, 16'h0000}, 1, ack);
		`CHK(ack, 1'b1)
		`CHK(iir_coef, 7'h7F)
		reg_wr(7'h77, {REG_COMMAND_TRIGGER, CMD_NOP, REG_COMMAND_TRIGGER, 8'h34}, 2, ack);
		`CHK(ack, 1'b0)
		`CHK(n_flush + n_sreset, 0)
		reg_wr(7'h77, {REG_COMMAND_TRIGGER, CMD_FIFO_FLUSH, 16'h0000}, 1, ack);
		`CHK(n_flush, 1)
		`CHK(iir_coef, 7'h7F)
		reg_rd(7'h77, REG_COMMAND_TRIGGER, 1, d);
		`CHK(d[7:0], 8'h00)
		reg_wr(7'h77, {REG_COMMAND_TRIGGER, CMD_SOFT_RESET, 16'h0000}, 1, ack);
		`CHK(n_sreset, 1)
		`CHK(iir_coef, 7'h00)
		reg_rd(7'h77, REG_ODR, 1, d);
		`CHK(d[7:0], 8'h00)
		i_shi_host.spi_frame({1'b0, REG_FILTER_SETUP[6:0]}, 8'h06, 2, rx);
		`CHK(iir_coef, 7'h07)
		i_shi_host.spi_frame({1'b1, REG_FILTER_SETUP[6:0]}, 8'hFF, 3, rx);
		`CHK(rx, 8'h06)
		i_shi_host.spi_frame({1'b0, REG_IF_CONF[6:0]}, 8'h01, 2, rx);
		i_shi_host.spi_frame({1'b1, REG_FILTER_SETUP[6:0]}, 8'hFF, 3, rx);
		`CHK(rx, 8'h06)
		i_shi_host.cpol = 1'b0;
		i_shi_host.spi_frame({1'b0, REG_COMMAND_TRIGGER[6:0]}, CMD_FIFO_FLUSH, 2, rx);
		`CHK(n_flush, 2)
		reg_wr(7'h77, {REG_FILTER_SETUP, 8'h0E, 16'h0000}, 1, ack);
		`CHK(ack, 1'b1)
		`CHK(iir_coef, 7'h07)
		rst = 1'b1;
		i_shi_host.wait_clk(2);
		rst = 1'b0;
		i_shi_host.wait_clk(6);
		reg_wr(7'h77, {REG_FILTER_SETUP, 8'h0E, 16'h0000}, 1, ack);
		`CHK(ack, 1'b0)
		`CHK(iir_coef, 7'h7F)
		close_out();
	end

	initial
	begin
		#600000;
		n_mismatch++;
		close_out();
	end
endmodule
